// file: pkg/crc16_cfg.svh
// constants for the 16-bit check engine: polynomial, seeds, flash block size
`ifndef CRC16_CFG_SVH
`define CRC16_CFG_SVH

`define CRC_POLY        16'h1021
`define CRC_SEED_ZERO   16'h0000
`define CRC_SEED_ONES   16'hFFFF
`define CRC_RESET_VALUE 16'h0000
`define CRC_BLOCK_BYTES 9'h100
`define CRC_BLOCK_LAST  8'hFF
`define CRC_ADDR_W      14

`endif

// file: pkg/crc16_pkg.sv
// types shared by the 16-bit check engine
`default_nettype none
package crc16_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [15:0] crc_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_WAIT  = 2'b10
    } scan_state_e;

    // one byte headed for the folding logic
    typedef struct packed {
        logic  reflect;
        byte_t data;
    } feed_s;
endpackage : crc16_pkg
`default_nettype wire

// file: hw/byte_skid_buf.sv
// two-entry buffer with valid/ready on both sides
`default_nettype none
module byte_skid_buf (
    input  wire logic            core_clk_i,
    input  wire logic            nrst_i,
    input  wire logic            in_valid_i,
    output logic                 in_ready_o,
    input  wire crc16_pkg::feed_s in_data_i,
    output logic                 out_valid_o,
    input  wire logic            out_ready_i,
    output crc16_pkg::feed_s     out_data_o
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    crc16_pkg::feed_s mem [2];
    crc16_pkg::feed_s next_mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       next_wr_ptr;
    logic       next_rd_ptr;
    logic [1:0] next_count;
    logic       push;
    logic       pop;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    // pointer and occupancy update
    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = in_data_i;
            next_wr_ptr      = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            mem    <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
endmodule : byte_skid_buf
`default_nettype wire

// file: hw/check_engine.sv
// 16-bit check engine over core-written bytes or automatic flash block scans
`default_nettype none
`include "crc16_cfg.svh"
// ----------------------------------------
// timing at a glance
// ----------------------------------------
// core byte: taken on an edge with valid and ready high,
// parked in the buffer, folded on the following edge
// scan: busy rises on the start edge, request one edge later;
// each flash byte costs a fetch edge plus the ack wait
// done pulses on the edge of the last ack, result one later
// limitation: core writes are refused for the whole scan
// seed load waits for an empty buffer so no byte is lost
module check_engine (
    input  wire logic                    core_clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    seed_load_i,
    input  wire logic                    seed_ones_i,
    input  wire logic                    reflect_i,
    input  wire logic                    wr_valid_i,
    input  wire crc16_pkg::byte_t        wr_data_i,
    output logic                         wr_ready_o,
    input  wire logic                    scan_start_i,
    input  wire logic [`CRC_ADDR_W-9:0]  scan_block_i,
    input  wire logic [7:0]              scan_count_i,
    output logic                         flash_req_o,
    output logic [`CRC_ADDR_W-1:0]       flash_addr_o,
    input  wire logic                    flash_ack_i,
    input  wire crc16_pkg::byte_t        flash_data_i,
    output logic                         busy_o,
    output logic                         done_o,
    output crc16_pkg::crc_t              result_o
);
    // ----------------------------------------
    // byte folding
    // ----------------------------------------
    // msb-first shift, eight steps unrolled by the loop
    function automatic crc16_pkg::crc_t fold(input crc16_pkg::crc_t c,
                                             input crc16_pkg::byte_t d);
        crc16_pkg::crc_t r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : fold

    // bit reversal of one byte, used when reflect is set
    function automatic crc16_pkg::byte_t flip(input crc16_pkg::byte_t d);
        crc16_pkg::byte_t r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return r;
    endfunction : flip

    // ----------------------------------------
    // scan sequencer state
    // ----------------------------------------
    crc16_pkg::scan_state_e      state;
    crc16_pkg::scan_state_e      next_state;
    logic [`CRC_ADDR_W-1:0]      addr;
    logic [`CRC_ADDR_W-1:0]      next_addr;
    logic [7:0]                  blocks_left;
    logic [7:0]                  next_blocks_left;
    logic                        next_flash_req;
    logic                        next_done;
    logic                        next_busy;
    crc16_pkg::crc_t             next_result;
    logic                        scanning;

    // buffer feed: flash bytes while scanning, core bytes otherwise
    logic                        buf_in_valid;
    logic                        buf_in_ready;
    crc16_pkg::feed_s            buf_in;
    logic                        buf_out_valid;
    crc16_pkg::feed_s            buf_out;
    logic                        next_wr_ready;

    // ----------------------------------------
    // byte source select
    // ----------------------------------------
    // scanning is any state but idle; the mux follows it
    assign scanning = (state != crc16_pkg::ST_IDLE);

    // reflect rides with the byte so a later change cannot touch it
    always_comb begin
        buf_in.reflect = reflect_i;
        if (scanning) begin
            buf_in_valid = (state == crc16_pkg::ST_WAIT) && flash_ack_i;
            buf_in.data  = flash_data_i;
        end else begin
            buf_in_valid = wr_valid_i && wr_ready_o;
            buf_in.data  = wr_data_i;
        end
    end

    // ----------------------------------------
    // two-entry buffer
    // ----------------------------------------
    // the fold drains every cycle, so its ready is tied high
    byte_skid_buf u_buf (
        .core_clk_i  (core_clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in),
        .out_valid_o (buf_out_valid),
        .out_ready_i (1'b1),
        .out_data_o  (buf_out)
    );

    // ----------------------------------------
    // sequencer next state
    // ----------------------------------------
    // a request is only raised while the buffer has room, so an ack
    // never meets a full buffer; seed load is ignored mid-scan
    always_comb begin
        next_state       = state;
        next_addr        = addr;
        next_blocks_left = blocks_left;
        next_flash_req   = 1'b0;
        next_done        = 1'b0;
        unique case (state)
            crc16_pkg::ST_IDLE: begin
                if (scan_start_i && !buf_out_valid) begin
                    next_addr        = {scan_block_i, 8'h00};
                    next_blocks_left = scan_count_i;
                    next_state       = crc16_pkg::ST_FETCH;
                end
            end
            crc16_pkg::ST_FETCH: begin
                if (buf_in_ready) begin
                    next_flash_req = 1'b1;
                    next_state     = crc16_pkg::ST_WAIT;
                end
            end
            crc16_pkg::ST_WAIT: begin
                next_flash_req = !flash_ack_i;
                if (flash_ack_i) begin
                    next_addr = addr + `CRC_ADDR_W'(1);
                    if (addr[7:0] == `CRC_BLOCK_LAST) begin
                        next_blocks_left = blocks_left - 8'h01;
                    end
                    // a count of zero is taken as one block
                    if (addr[7:0] == `CRC_BLOCK_LAST && blocks_left <= 8'h01) begin
                        next_state = crc16_pkg::ST_IDLE;
                        next_done  = 1'b1;
                    end else begin
                        next_state = crc16_pkg::ST_FETCH;
                    end
                end
            end
            default: begin
                next_state = crc16_pkg::ST_IDLE; // unused code falls back to idle
            end
        endcase
    end

    // ----------------------------------------
    // running check value
    // ----------------------------------------
    // one byte leaves the buffer and is folded every cycle
    always_comb begin
        next_result   = result_o;
        next_busy     = (next_state != crc16_pkg::ST_IDLE);
        // core writes open only when idle and the buffer has room
        next_wr_ready = !next_flash_req && !next_busy && buf_in_ready;
        if (seed_load_i && !scanning && !buf_out_valid) begin
            next_result = seed_ones_i ? `CRC_SEED_ONES : `CRC_SEED_ZERO;
        end else if (buf_out_valid) begin
            next_result = fold(result_o, buf_out.reflect ? flip(buf_out.data)
                                                         : buf_out.data);
        end
    end

    // ----------------------------------------
    // state and output registers
    // ----------------------------------------
    // outputs straight from flops; nothing but registering here
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state       <= crc16_pkg::ST_IDLE;
            addr        <= '0;
            blocks_left <= 8'h00;
            flash_req_o <= 1'b0;
            done_o      <= 1'b0;
            busy_o      <= 1'b0;
            wr_ready_o  <= 1'b0;
            result_o    <= `CRC_RESET_VALUE;
        end else begin
            state       <= next_state;
            addr        <= next_addr;
            blocks_left <= next_blocks_left;
            flash_req_o <= next_flash_req;
            done_o      <= next_done;
            busy_o      <= next_busy;
            wr_ready_o  <= next_wr_ready;
            result_o    <= next_result;
        end
    end

    // ----------------------------------------
    // flash address output
    // ----------------------------------------
    // address register tracks the byte being fetched
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flash_addr_o <= '0;
        end else begin
            flash_addr_o <= next_addr;
        end
    end
endmodule : check_engine
`default_nettype wire

// file: sim/flash_model.sv
// flash read port model with a settable answer delay
`default_nettype none
module flash_model (
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        flash_req_i,
    input  wire logic [13:0] flash_addr_i,
    input  wire logic [3:0]  lag_i,
    output logic             flash_ack_o,
    output crc16_pkg::byte_t flash_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    crc16_pkg::byte_t mem [16384];
    logic [3:0]       cnt;
    // answer lag_i+1 cycles after a request rises; data toggles otherwise so a stale byte never looks valid
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flash_ack_o  <= 1'h0;
            flash_data_o <= 8'h5A;
            cnt          <= 4'h0;
        end else begin
            flash_ack_o  <= 1'h0;
            flash_data_o <= ~flash_data_o;
            if (flash_req_i && !flash_ack_o) begin
                cnt <= (cnt == lag_i) ? 4'h0 : cnt + 4'h1;
                if (cnt == lag_i) begin
                    flash_ack_o  <= 1'h1;
                    flash_data_o <= mem[flash_addr_i];
                end
            end
        end
    end
endmodule : flash_model
`default_nettype wire

// file: sim/check_engine_sva.sv
// port checker for the check engine
`default_nettype none
`include "crc16_cfg.svh"
module check_engine_sva (
    input wire logic             core_clk_i,
    input wire logic             nrst_i,
    input wire logic             seed_load_i,
    input wire logic             seed_ones_i,
    input wire logic             reflect_i,
    input wire logic             wr_valid_i,
    input wire crc16_pkg::byte_t wr_data_i,
    input wire logic             wr_ready_o,
    input wire logic             scan_start_i,
    input wire logic [5:0]       scan_block_i,
    input wire logic             flash_req_o,
    input wire logic [13:0]      flash_addr_o,
    input wire logic             flash_ack_i,
    input wire crc16_pkg::byte_t flash_data_i,
    input wire logic             busy_o,
    input wire logic             done_o,
    input wire crc16_pkg::crc_t  result_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic             tk;
    crc16_pkg::byte_t td;
    logic [1:0]       calm;
    logic             ok;
    // msb-first fold, bit order flipped when reflect is set
    function automatic crc16_pkg::crc_t fold(crc16_pkg::crc_t c, crc16_pkg::byte_t d, logic r);
        for (int i = 7; i >= 0; i--) begin
            c = {c[14:0], 1'h0} ^ ((c[15] ^ d[r ? 7 - i : i]) ? `CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : fold
    // a byte taken from either source; ok means three quiet cycles, so the buffer is empty
    assign tk = (wr_valid_i && wr_ready_o) || (flash_req_o && flash_ack_i);
    assign td = (wr_valid_i && wr_ready_o) ? wr_data_i : flash_data_i;
    assign ok = calm == 2'h3 && !tk && !busy_o && !done_o;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            calm <= 2'h0;
        end else begin
            calm <= (tk || busy_o || done_o) ? 2'h0 : (calm == 2'h3 ? calm : calm + 2'h1);
        end
    end
    AST_FOLD: assert property (tk |-> ##2 result_o ==
        fold($past(result_o), $past(td, 2), $past(reflect_i, 2))) else $error("bad fold");
    AST_SEED: assert property (seed_load_i && ok |=>
        result_o == ($past(seed_ones_i) ? `CRC_SEED_ONES : `CRC_SEED_ZERO)) else $error("bad seed");
    AST_START: assert property (scan_start_i && ok |=> busy_o ##1
        (flash_req_o && flash_addr_o == {$past(scan_block_i, 2), 8'h00})) else $error("bad start");
    AST_HOLD: assert property (flash_req_o && !flash_ack_i |=>
        flash_req_o && $stable(flash_addr_o)) else $error("request dropped");
    AST_STEP: assert property (flash_req_o && flash_ack_i |=> !flash_req_o ##1
        ((flash_req_o && flash_addr_o == $past(flash_addr_o, 2) + 14'h0001) || $past(done_o)))
        else $error("bad address step");
    AST_DONE: assert property (done_o |-> $past(flash_req_o && flash_ack_i) ##1 !done_o)
        else $error("bad done pulse");
    AST_BLOCK: assert property (busy_o |-> !wr_ready_o) else $error("write open in scan");
    cover property (tk ##1 tk);
    cover property (done_o);
    cover property (seed_load_i && seed_ones_i && ok);
endmodule : check_engine_sva
bind check_engine check_engine_sva u_sva (.*);
`default_nettype wire

// file: sim/crc16_byte_engine_bench.sv
// bench: core writes, seeds and flash scans against a reference fold
`default_nettype none
`include "crc16_cfg.svh"
module crc16_byte_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'h0, nrst_i = 1'h0, seed_load_i = 1'h0, seed_ones_i = 1'h0, fin = 1'h0;
    logic reflect_i = 1'h0, wr_valid_i = 1'h0, scan_start_i = 1'h0;
    logic wr_ready_o, flash_req_o, flash_ack_i, busy_o, done_o;
    logic [5:0]  scan_block_i = 6'h00;
    logic [7:0]  scan_count_i = 8'h00;
    logic [13:0] flash_addr_o;
    logic [3:0]  lag = 4'h0;
    logic [1:0]  took = 2'h0;
    logic [31:0] lfsr = 32'h6CB7;
    crc16_pkg::byte_t wr_data_i = 8'h00, flash_data_i;
    crc16_pkg::crc_t  result_o, model = 16'h0000, exp_q[$];
    int errors = 0, checks = 0;
    check_engine DUT (.core_clk_i, .nrst_i, .seed_load_i, .seed_ones_i, .reflect_i, .wr_valid_i,
        .wr_data_i, .wr_ready_o, .scan_start_i, .scan_block_i, .scan_count_i, .flash_req_o,
        .flash_addr_o, .flash_ack_i, .flash_data_i, .busy_o, .done_o, .result_o);
    flash_model flash (.core_clk_i, .nrst_i, .flash_req_i(flash_req_o),
        .flash_addr_i(flash_addr_o), .lag_i(lag), .flash_ack_o(flash_ack_i),
        .flash_data_o(flash_data_i));
    always #10 core_clk_i = ~core_clk_i;
    // ----
    // reference and helpers
    // ----
    function automatic logic [31:0] step(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : step
    // taps of x^16 + x^12 + x^5 + 1 written out bit by bit
    function automatic crc16_pkg::crc_t fold(crc16_pkg::crc_t c, crc16_pkg::byte_t d, logic r);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ (r ? d[7 - i] : d[i]);
            c = {c[14:0], 1'h0} ^ {3'h0, fb, 6'h00, fb, 4'h0, fb};
        end
        return c;
    endfunction : fold
    task automatic check(string what, crc16_pkg::crc_t seen, crc16_pkg::crc_t want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic final_report();
        // a note never taken means a result never showed up
        if (exp_q.size() != 0) begin
            errors++;
            $display("mismatch queue expected 0 seen %0d", exp_q.size());
        end
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic idle(int k);
        {wr_valid_i, seed_load_i, scan_start_i} = 3'h0;
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask : idle
    task automatic tell(string s);
        idle(3);
        $display("test done: %s", s);
    endtask : tell
    // valid is held across calls so bytes go back to back
    task automatic put(crc16_pkg::byte_t d, logic r);
        {wr_valid_i, wr_data_i, reflect_i} = {1'h1, d, r};
        model = fold(model, d, r);
        exp_q.push_back(model);
        repeat (50) begin
            @(posedge core_clk_i);
            if (wr_ready_o === 1'h1) break;
        end
        if (wr_ready_o !== 1'h1) begin
            errors++;
            final_report();
        end
        #1;
    endtask : put
    task automatic seed(logic ones);
        idle(3);
        {seed_load_i, seed_ones_i} = {1'h1, ones};
        model = ones ? `CRC_SEED_ONES : `CRC_SEED_ZERO;
        exp_q.push_back(model);
        // the strobe must stand across one edge before it drops
        @(posedge core_clk_i);
        #1;
        idle(2);
    endtask : seed
    task automatic scan(logic [5:0] blk, logic [7:0] cnt, logic r);
        idle(3);
        {scan_start_i, scan_block_i, scan_count_i, reflect_i} = {1'h1, blk, cnt, r};
        for (int a = 256 * blk; a < 256 * (blk + (cnt == 0 ? 1 : cnt)); a++)
            model = fold(model, flash.mem[a], r);
        exp_q.push_back(model);
        // start stands across one edge, then drops
        @(posedge core_clk_i);
        #1;
        scan_start_i = 1'h0;
        repeat (20000) begin
            @(posedge core_clk_i);
            if (done_o === 1'h1) break;
        end
        if (done_o !== 1'h1) begin
            errors++;
            final_report();
        end
        idle(2);
    endtask : scan
    // results land two falling edges after a take, one after a seed or done
    always @(negedge core_clk_i) begin
        if ((took[1] || fin) && exp_q.size() == 0) begin
            errors++;
            $display("mismatch result expected a queued note seen %h", result_o);
        end else if (took[1] || fin) begin
            check("result", result_o, exp_q.pop_front());
        end
        took = {took[0], wr_valid_i && wr_ready_o};
        fin = done_o || seed_load_i;
    end
    initial begin
        foreach (flash.mem[a]) begin
            lfsr = step(lfsr);
            flash.mem[a] = lfsr[7:0];
        end
        repeat (8) @(posedge core_clk_i);
        #1 nrst_i = 1'h1;
        idle(2);
        for (int s = 0; s < 2; s++) begin
            seed(s[0]);
            for (int i = 0; i < 40; i++) begin
                lfsr = step(lfsr);
                put(lfsr[7:0], lfsr[8]);
            end
            tell("back to back writes");
        end
        scan(6'h00, 8'h00, 1'h0);
        tell("one block scan");
        lag = 4'h3;
        seed(1'h1);
        scan(6'h3E, 8'h02, 1'h1);
        put(8'hA5, 1'h0);
        tell("slow two block scan at top");
        final_report();
    end
endmodule : crc16_byte_engine_bench
`default_nettype wire
